// *** ckrat_ctrl.sv ***
`timescale 1ns/100ps
module ckrat_ctrl
   import ckrat_pkg::*;
#(
   parameter int MODE_W = 3
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic manual_rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [1:0] size,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire logic [MODE_W-1:0] clock_mode,
   input wire logic state_out_hi,
   input wire logic state_out_lo,
   input wire logic ext_clock_pin_i,
   output logic ext_clock_pin_o,
   output logic ext_clock_pin_oe_n,
   output logic [RATIO_W-1:0] pll_mult,
   output logic [RATIO_W-1:0] core_div,
   output logic [RATIO_W-1:0] periph_div,
   output logic settle_req,
   output logic core_tick,
   output logic periph_tick,
   output logic [1:0] usb_src_sel,
   output logic usb_clk_run,
   output logic usb_osc_enable
);

   logic [DATA_W-1:0] frq_q;
   logic [7:0] usb_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic word_acc;
   logic wr_frq;
   logic wr_usb;
   logic [DATA_W-1:0] frq_new;
   logic pin_q;
   logic pin_oe_n_q;
   logic tgl_q;
   logic settle_q;
   logic usb_run_q;
   ckrat_pin_e pin_mode;
   logic [RATIO_W-1:0] mult_f;
   logic [RATIO_W-1:0] cdiv_f;
   logic [RATIO_W-1:0] pdiv_f;
   logic [1:0] tick_q;

   assign word_acc = (size == SIZE_WORD);
   assign wr_frq = wr && word_acc && (addr == OFS_FREQ);
   assign wr_usb = wr && word_acc && (addr == OFS_USB) && (wdata[DATA_W-1:8] == USB_KEY);

   assign frq_new = wdata & FRQ_WMASK;

   assign mult_f = frq_q[FRQ_MULT_LSB +: RATIO_W];
   assign cdiv_f = frq_q[FRQ_CDIV_LSB +: RATIO_W];
   assign pdiv_f = frq_q[FRQ_PDIV_LSB +: RATIO_W];

   // frequency register; a manual reset restores it like power-on does
   // enable resets to one
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         frq_q <= FRQ_RESET;
      end else if (manual_rst) begin
         frq_q <= FRQ_RESET;
      end else if (wr_frq) begin
         frq_q <= frq_new;
      end
   end

   // source and oscillator bits reset to ones
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         usb_q <= USB_RESET;
      end else if (wr_usb) begin
         usb_q <= wdata[7:0] & USB_WMASK;
      end
   end

   // read mux; a non-word or unmapped read answers zero
   always_comb begin
      rdata_d = '0;
      if (rd && word_acc) begin
         unique case (addr)
            OFS_FREQ: rdata_d = frq_q;
            OFS_USB: rdata_d = {8'h00, usb_q};
            OFS_STAT: begin
               rdata_d[STAT_MODE_LSB +: MODE_W] = clock_mode;
               rdata_d[STAT_PIN_BIT] = ext_clock_pin_i;
               rdata_d[STAT_HOLD_BIT] = (pin_mode == CKRAT_PIN_HOLD);
               rdata_d[STAT_INPUT_BIT] = (pin_mode == CKRAT_PIN_INPUT);
            end
            default: rdata_d = '0;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // pin mode; mode 7 overrides everything
   always_comb begin
      // mode 7 makes the pin an input
      if (clock_mode == MODE_PIN_INPUT) begin
         pin_mode = CKRAT_PIN_INPUT;
      end else if (!frq_q[FRQ_EXT_CLOCK_OUTPUT_ENABLE_BIT] && !state_out_hi && state_out_lo) begin
         pin_mode = CKRAT_PIN_HOLD;
      end else begin
         pin_mode = CKRAT_PIN_DRIVE;
      end
   end

   // free-running half-rate toggle as the pin clock source
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tgl_q <= 1'b0;
      end else begin
         tgl_q <= ~tgl_q;
      end
   end

   // pin drive registered so the output has no glitches from the mode decode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
      end else begin
         unique case (pin_mode)
            CKRAT_PIN_DRIVE: begin
               pin_q <= ~tgl_q;
               pin_oe_n_q <= 1'b0;
            end
            CKRAT_PIN_HOLD: begin
               pin_q <= 1'b0;
               pin_oe_n_q <= 1'b0;
            end
            CKRAT_PIN_INPUT: begin
               pin_q <= 1'b0;
               pin_oe_n_q <= 1'b1;
            end
            default: begin
               pin_q <= 1'b0;
               pin_oe_n_q <= 1'b1;
            end
         endcase
      end
   end

   // only a multiplier change asks for settling
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         settle_q <= 1'b0;
      end else begin
         settle_q <= wr_frq && !manual_rst && (frq_new[FRQ_MULT_LSB +: RATIO_W] != mult_f);
      end
   end

   // ratio tick generators, one per divided clock; a new ratio restarts the count, with a tick, on the edge after it is loaded
   // so the next tick already follows the new division
   generate
      for (genvar g = 0; g < 2; g++) begin : g_div
         logic [RATIO_W-1:0] cnt_q;
         logic [RATIO_W-1:0] ratio;
         logic [RATIO_W-1:0] ratio_prev_q;
         assign ratio = (g == 0) ? cdiv_f : pdiv_f;
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               ratio_prev_q <= '0;
            end else begin
               ratio_prev_q <= ratio;
            end
         end
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               cnt_q <= '0;
               tick_q[g] <= 1'b0;
            end else if (ratio != ratio_prev_q || cnt_q >= ratio) begin
               cnt_q <= '0;
               tick_q[g] <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
               tick_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // code 00 stops the usb clock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         usb_run_q <= 1'b1;
      end else begin
         usb_run_q <= (usb_q[USB_SRC_LSB +: 2] != USB_SRC_STOP);
      end
   end

   assign rdata = rdata_q;
   assign ext_clock_pin_o = pin_q;
   assign ext_clock_pin_oe_n = pin_oe_n_q;
   // multiplier code is factor minus one
   assign pll_mult = mult_f;
   assign core_div = cdiv_f;
   assign periph_div = pdiv_f;
   assign settle_req = settle_q;
   assign core_tick = tick_q[0];
   assign periph_tick = tick_q[1];
   assign usb_src_sel = usb_q[USB_SRC_LSB +: 2];
   assign usb_clk_run = usb_run_q;
   assign usb_osc_enable = usb_q[USB_OSC_BIT];

endmodule

// *** ckrat_ctrl_assertions.sv ***
`timescale 1ns/100ps
module ckrat_chk
   import ckrat_pkg::*;
#(
   parameter int MODE_W = 3
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic manual_rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [1:0] size,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic [MODE_W-1:0] clock_mode,
   input wire logic ext_clock_pin_oe_n,
   input wire logic [RATIO_W-1:0] pll_mult,
   input wire logic [RATIO_W-1:0] core_div,
   input wire logic [RATIO_W-1:0] periph_div,
   input wire logic [1:0] usb_src_sel,
   input wire logic usb_osc_enable
);
   logic wf;
   logic wu;
   // manual reset wins over a same-cycle write, so it is kept out of wf
   assign wf = wr && size == SIZE_WORD && addr == OFS_FREQ && !manual_rst;
   assign wu = wr && size == SIZE_WORD && addr == OFS_USB;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_rsz; rd && size != SIZE_WORD |=> rdata == '0; endproperty
   a_rsz: assert property (p_rsz) else $error("odd size read not zero");
   property p_mul; wf |=> pll_mult == $past(wdata[9:8]); endproperty
   a_mul: assert property (p_mul) else $error("multiplier not taken");
   property p_div; wf |=> core_div == $past(wdata[5:4]) && periph_div == $past(wdata[1:0]); endproperty
   a_div: assert property (p_div) else $error("dividers not taken at once");
   property p_man; manual_rst |=> pll_mult == 2'h0 && core_div == 2'h0 && periph_div == 2'h3; endproperty
   a_man: assert property (p_man) else $error("manual reset fields wrong");
   property p_m7; clock_mode == MODE_PIN_INPUT |=> ext_clock_pin_oe_n; endproperty
   a_m7: assert property (p_m7) else $error("pin driven in mode 7");
   property p_key; wu && wdata[15:8] == USB_KEY |=> usb_src_sel == $past(wdata[7:6]) && usb_osc_enable == $past(wdata[5]); endproperty
   a_key: assert property (p_key) else $error("keyed usb write lost");
   property p_nok; wu && wdata[15:8] != USB_KEY |=> $stable(usb_src_sel) && $stable(usb_osc_enable); endproperty
   a_nok: assert property (p_nok) else $error("usb write without key taken");
   property p_mus; manual_rst && !wu |=> $stable(usb_src_sel) && $stable(usb_osc_enable); endproperty
   a_mus: assert property (p_mus) else $error("manual reset touched usb");
   c_mul: cover property (wf && wdata[9:8] != pll_mult);
   c_man: cover property (manual_rst);
   c_nok: cover property (wu && wdata[15:8] != USB_KEY);
endmodule
bind ckrat_ctrl ckrat_chk #(.MODE_W(MODE_W)) u_ckrat_chk (.clk, .arst_n, .manual_rst, .addr, .wdata, .size,
   .wr, .rd, .rdata, .clock_mode, .ext_clock_pin_oe_n, .pll_mult, .core_div, .periph_div, .usb_src_sel,
   .usb_osc_enable);

// *** ckrat_pkg.sv ***
package ckrat_pkg;
   // register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] OFS_FREQ = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_USB = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;

   // access size encodings on the size port
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_LONG = 2'h2;

   // clock_frequency_control layout
   localparam int FRQ_EXT_CLOCK_OUTPUT_ENABLE_BIT = 12;
   localparam int FRQ_MULT_LSB = 8;
   localparam int FRQ_CDIV_LSB = 4;
   localparam int FRQ_PDIV_LSB = 0;
   localparam logic [DATA_W-1:0] FRQ_RESET = 16'h1003;
   localparam logic [DATA_W-1:0] FRQ_WMASK = 16'h1333;

   // usb_clock_control layout
   localparam int USB_SRC_LSB = 6;
   localparam int USB_OSC_BIT = 5;
   localparam logic [7:0] USB_RESET = 8'he0;
   localparam logic [7:0] USB_WMASK = 8'he0;
   localparam logic [7:0] USB_KEY = 8'ha5;
   localparam logic [1:0] USB_SRC_STOP = 2'h0;
   localparam logic [1:0] USB_SRC_EXT = 2'h3;

   // status register layout
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_PIN_BIT = 3;
   localparam int STAT_HOLD_BIT = 4;
   localparam int STAT_INPUT_BIT = 5;

   // clock operating mode in which the external pin is an input
   localparam logic [2:0] MODE_PIN_INPUT = 3'h7;

   // ratio codes are the divide or multiply factor minus one
   localparam int RATIO_W = 2;

   typedef enum logic [1:0] {
      CKRAT_PIN_DRIVE,
      CKRAT_PIN_HOLD,
      CKRAT_PIN_INPUT
   } ckrat_pin_e;
endpackage

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   import ckrat_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, manual_rst = 1'b0, wr = 1'b0, rd = 1'b0, p;
   logic state_out_hi = 1'b0, state_out_lo = 1'b0, ext_clock_pin_i = 1'b0;
   logic ext_clock_pin_o, ext_clock_pin_oe_n, settle_req, usb_clk_run, usb_osc_enable;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata, mf = 16'h1003, d;
   logic [1:0] size = SIZE_WORD, pll_mult, core_div, periph_div, usb_src_sel;
   logic [2:0] clock_mode = 3'h0;
   logic [7:0] mu = 8'he0;
   logic [31:0] lf = 32'hd2a6;
   logic [15:0] lg [12] = '{16'h1000, 16'h1001, 16'h1003, 16'h1101, 16'h1103, 16'h1111,
      16'h1113, 16'h1202, 16'h1222, 16'h1303, 16'h1313, 16'h1333};
   logic core_tick, periph_tick;
   int error_cnt = 0, samples_checked = 0, cyc = 0, n = 0, m = 0;
   ckrat_ctrl u_ckrat_ctrl (.clk, .arst_n, .manual_rst, .addr, .wdata, .size, .wr, .rd, .rdata, .clock_mode,
      .state_out_hi, .state_out_lo, .ext_clock_pin_i, .ext_clock_pin_o, .ext_clock_pin_oe_n, .pll_mult,
      .core_div, .periph_div, .settle_req, .core_tick, .periph_tick, .usb_src_sel, .usb_clk_run,
      .usb_osc_enable);
   initial forever #4 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         wrap_up();
      end
   end
   function automatic logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   // trailing idle edge lets the lagging usb_clk_run settle
   task automatic wt(input logic [7:0] a, input logic [15:0] v, input logic [1:0] s);
      addr <= a;
      wdata <= v;
      size <= s;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1 chk(settle_req, s == SIZE_WORD && a == OFS_FREQ && v[9:8] != mf[9:8]);
      if (s == SIZE_WORD && a == OFS_FREQ) mf = v & 16'h1333;
      if (s == SIZE_WORD && a == OFS_USB && v[15:8] == 8'ha5) mu = v[7:0] & 8'he0;
      @(posedge clk);
   endtask
   task automatic rt(input logic [7:0] a, input logic [1:0] s);
      logic [15:0] e;
      e = (s != SIZE_WORD) ? 16'h0000 : (a == OFS_FREQ) ? mf : (a == OFS_USB) ? {8'h00, mu} :
         (a == OFS_STAT) ? {10'h000, clock_mode == 3'h7, clock_mode != 3'h7 && !mf[12] && !state_out_hi &&
         state_out_lo, ext_clock_pin_i, clock_mode} : 16'h0000;
      addr <= a;
      size <= s;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
      @(posedge clk);
   endtask
   task automatic fc();
      chk({6'h00, pll_mult, core_div, periph_div, usb_src_sel, usb_osc_enable, usb_clk_run},
         {6'h00, mf[9:8], mf[5:4], mf[1:0], mu[7:6], mu[5], mu[7:6] != 2'h0});
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rt(OFS_FREQ, SIZE_WORD);
      rt(OFS_USB, SIZE_WORD);
      fc();
      $display("reset values done");
      for (int i = 0; i < 40; i++) begin
         lf = nx(lf);
         ext_clock_pin_i <= lf[7];
         d = lf[0] ? {(lf[1] ? 8'ha5 : 8'h5a), (lf[2] ? 2'h3 : 2'h0), lf[3], 5'h00} : lg[lf[11:8] % 12] ^ {lf[4], 12'h000};
         wt(lf[0] ? OFS_USB : OFS_FREQ, d, (lf[6:5] == 2'h3) ? SIZE_WORD : lf[6:5]);
         rt(OFS_FREQ, lf[9] ? SIZE_WORD : SIZE_BYTE);
         rt(OFS_USB, lf[10] ? SIZE_WORD : SIZE_LONG);
         fc();
      end
      rt(8'h10, SIZE_WORD);
      wt(OFS_FREQ, 16'h1313, SIZE_WORD);
      repeat (3) @(posedge clk);
      repeat (12) begin
         @(posedge clk);
         #1 n += core_tick;
         m += periph_tick;
      end
      chk(16'(n), 16'h0006);
      chk(16'(m), 16'h0003);
      $display("random access done");
      clock_mode <= 3'h7;
      wt(OFS_FREQ, 16'h0003, SIZE_WORD);
      state_out_lo <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk(ext_clock_pin_oe_n, 1'b1);
      @(posedge clk);
      rt(OFS_STAT, SIZE_WORD);
      clock_mode <= 3'h0;
      repeat (2) @(posedge clk);
      #1 chk({ext_clock_pin_o, ext_clock_pin_oe_n}, 2'h0);
      @(posedge clk);
      rt(OFS_STAT, SIZE_WORD);
      wt(OFS_FREQ, 16'h1003, SIZE_WORD);
      #1 p = ext_clock_pin_o;
      @(posedge clk);
      // xor with the last sample so an unknown pin never matches
      #1 chk({ext_clock_pin_o ^ p, ext_clock_pin_oe_n}, 2'h2);
      @(posedge clk);
      $display("pin test done");
      wt(OFS_FREQ, 16'h1333, SIZE_WORD);
      wt(OFS_USB, 16'ha500, SIZE_WORD);
      manual_rst <= 1'b1;
      @(posedge clk);
      manual_rst <= 1'b0;
      mf = 16'h1003;
      @(posedge clk);
      fc();
      arst_n <= 1'b0;
      @(posedge clk);
      arst_n <= 1'b1;
      mu = 8'he0;
      @(posedge clk);
      fc();
      $display("reset kinds done");
      wrap_up();
   end
endmodule
